// File: common/scp_cfg.svh
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

// ascii codes that steer the parser
`define SCP_CH_CR 8'h0d
`define SCP_CH_LF 8'h0a
`define SCP_CH_SP 8'h20
`define SCP_CH_COLON 8'h3a
`define SCP_CH_SEMI 8'h3b
`define SCP_CH_COMMA 8'h2c
`define SCP_CH_QUERY 8'h3f
`define SCP_CH_LPAR 8'h28
`define SCP_CH_RPAR 8'h29
`define SCP_CH_AT 8'h40
`define SCP_CH_DASH 8'h2d
`define SCP_CH_PLUS 8'h2b
`define SCP_CH_DOT 8'h2e
`define SCP_CH_STAR 8'h2a
`define SCP_CH_ONE 8'h31
`define SCP_CH_EXP 8'h45
// virtual character seen past the end of the stored line
`define SCP_CH_EOL 8'h00

// receive line buffer, characters without the cr lf pair
`define SCP_RX_DEPTH 80
// output channels served by one command
`define SCP_CHANNELS 8

`endif

// File: common/scp_pkg.sv
package scp_pkg;

  typedef enum logic [2:0] {
    SCP_CMD_NONE,
    SCP_CMD_VOLT,
    SCP_CMD_CURR,
    SCP_CMD_MEAS_VOLT,
    SCP_CMD_MEAS_CURR,
    SCP_CMD_OPC
  } scp_cmd_t;

  typedef enum logic {
    SCP_LV_ROOT,
    SCP_LV_MEAS
  } scp_level_t;

  typedef enum {
    SCP_S_RX,
    SCP_S_FETCH,
    SCP_S_CHAR,
    SCP_S_EXEC,
    SCP_S_SEP,
    SCP_S_ANS,
    SCP_S_OPC,
    SCP_S_CR,
    SCP_S_LF
  } scp_state_t;

  typedef enum {
    SCP_P_LEAD,
    SCP_P_KW,
    SCP_P_POST,
    SCP_P_PARAM,
    SCP_P_PEND,
    SCP_P_COMMA,
    SCP_P_AT,
    SCP_P_CHN,
    SCP_P_TAIL
  } scp_phase_t;

endpackage

// File: hdl/scp_line_mem.sv
`timescale 1ns/1ps
module scp_line_mem #(
  parameter int W = 8,
  parameter int DEPTH = 80,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we && (int'(waddr) < DEPTH))
      mem[waddr] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
  end
endmodule

// File: hdl/scp_parser.sv
`timescale 1ns/1ps
`include "scp_cfg.svh"
module scp_parser
  import scp_pkg::*;
#(
  parameter int CHANNELS = `SCP_CHANNELS,
  parameter int DEPTH = `SCP_RX_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic echo_valid,
  output logic [7:0] echo_data,
  output logic cmd_valid,
  output scp_cmd_t cmd_code,
  output logic cmd_query,
  output logic [$clog2(CHANNELS)-1:0] cmd_chan,
  output logic [31:0] cmd_value,
  output logic cmd_neg,
  input wire logic ans_valid,
  input wire logic [7:0] ans_data,
  input wire logic ans_last,
  output logic ans_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic line_error
);
  localparam int CW = $clog2(CHANNELS);
  localparam int AW = $clog2(DEPTH + 2);

  function automatic logic [7:0] upcase(input logic [7:0] ch);
    upcase = (ch >= 8'h61 && ch <= 8'h7a) ? ch - 8'h20 : ch;
  endfunction

  function automatic logic is_digit(input logic [7:0] ch);
    is_digit = ch >= 8'h30 && ch <= 8'h39;
  endfunction

  function automatic logic is_alpha(input logic [7:0] ch);
    is_alpha = ch >= 8'h41 && ch <= 8'h5a;
  endfunction

  function automatic scp_cmd_t leaf_of(input scp_level_t lv, input logic [63:0] k);
    leaf_of = SCP_CMD_NONE;
    if (k == 64'("VOLT") || k == 64'("VOLTAGE"))
      leaf_of = (lv == SCP_LV_ROOT) ? SCP_CMD_VOLT : SCP_CMD_MEAS_VOLT;
    else if (k == 64'("CURR") || k == 64'("CURRENT"))
      leaf_of = (lv == SCP_LV_ROOT) ? SCP_CMD_CURR : SCP_CMD_MEAS_CURR;
    else if (k == 64'("*OPC") && lv == SCP_LV_ROOT)
      leaf_of = SCP_CMD_OPC;
  endfunction

  function automatic logic [CHANNELS-1:0] span(input logic [7:0] lo, input logic [7:0] hi);
    for (int i = 0; i < CHANNELS; i++)
      span[i] = (i >= int'(lo)) && (i <= int'(hi));
  endfunction

  function automatic logic [CW-1:0] lowest(input logic [CHANNELS-1:0] m);
    lowest = '0;
    for (int i = CHANNELS - 1; i >= 0; i--)
      if (m[i])
        lowest = CW'(i);
  endfunction

  logic rst_meta_b_q, rst_sync_b_q;
  scp_state_t st_q, nxt_q;
  scp_phase_t ph_q, eph;
  scp_level_t level_q;
  scp_cmd_t cmd_q, leaf;
  logic pass2_q, prev_cr_q, bad_q, query_q, has_p_q, p_str_q, p_neg_q, p_frac_q, p_exp_q;
  logic chd_q, rng_q, any_ans_q, first_ch_q, loaded_q, cmd_first_q;
  logic [AW-1:0] p_q, len_q;
  logic [63:0] kw_q, kw_nx, str_nx;
  logic [31:0] val_q;
  logic [35:0] val_nx;
  logic [11:0] chn_nx;
  logic [7:0] chn_q, lo_q, c, mem_rdata, sep_q;
  logic [CHANNELS-1:0] mask_q, work_q, work_nx;
  logic [CW-1:0] ch, ch_last_q;
  logic fail_c, end_c, term, str_ok, rx_take, tx_take, ans_take, line_end, rx_store;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_b_q <= 1'b0;
      rst_sync_b_q <= 1'b0;
    end
    else
    begin
      rst_meta_b_q <= 1'b1;
      rst_sync_b_q <= rst_meta_b_q;
    end
  end

  assign rx_take = rx_valid && rx_ready;
  assign tx_take = tx_valid && tx_ready;
  assign ans_take = ans_valid && ans_ready;
  assign line_end = rx_take && rx_data == `SCP_CH_LF && prev_cr_q;
  assign rx_store = rx_take && rx_data != `SCP_CH_CR && !line_end;
  assign c = (p_q >= len_q) ? `SCP_CH_EOL : upcase(mem_rdata);
  assign kw_nx = {kw_q[55:0], c};
  assign str_nx = has_p_q ? kw_nx : {56'h0, c};
  assign str_ok = kw_q == 64'("ON") || kw_q == 64'("OFF");
  assign leaf = leaf_of(level_q, kw_q);
  assign val_nx = ({4'h0, val_q} << 3) + ({4'h0, val_q} << 1) + {32'h0, c[3:0]};
  assign chn_nx = ({4'h0, chn_q} << 3) + ({4'h0, chn_q} << 1) + {8'h0, c[3:0]};
  assign term = c == `SCP_CH_SEMI || c == `SCP_CH_EOL;
  assign ch = lowest(work_q);
  assign work_nx = work_q & ~(CHANNELS'(1) << ch);

  scp_line_mem #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(mclk),
    .we(rx_store && int'(len_q) < DEPTH),
    .waddr(len_q),
    .wdata(rx_data),
    .raddr(p_q),
    .rdata(mem_rdata)
  );

  always_comb
  begin
    eph = ph_q;
    if (ph_q == SCP_P_POST && !query_q && c != `SCP_CH_SP && c != `SCP_CH_LPAR && !term)
      eph = SCP_P_PARAM;
  end

  // syntax check of the current character
  always_comb
  begin
    fail_c = 1'b0;
    end_c = 1'b0;
    case (eph)
      SCP_P_LEAD: fail_c = !(c == `SCP_CH_SP || c == `SCP_CH_COLON || c == `SCP_CH_EOL
        || is_alpha(c) || c == `SCP_CH_STAR);
      SCP_P_KW:
        if (is_alpha(c) || is_digit(c) || c == `SCP_CH_STAR)
          fail_c = kw_q[63:56] != 8'h00;
        else if (c == `SCP_CH_COLON)
          fail_c = level_q != SCP_LV_ROOT || !(kw_q == 64'("MEAS") || kw_q == 64'("MEASURE"));
        else if (c == `SCP_CH_QUERY)
          fail_c = leaf == SCP_CMD_NONE;
        else if (c == `SCP_CH_SP)
          fail_c = !(leaf == SCP_CMD_VOLT || leaf == SCP_CMD_CURR);
        else
          fail_c = 1'b1;
      SCP_P_POST:
        if (c == `SCP_CH_LPAR || term)
        begin
          fail_c = !query_q;
          end_c = term;
        end
        else
          fail_c = c != `SCP_CH_SP;
      SCP_P_PARAM:
        if (is_digit(c))
          fail_c = p_str_q || (!p_frac_q && !p_exp_q && val_nx[35:32] != 4'h0);
        else if (c == `SCP_CH_DOT)
          fail_c = p_str_q || p_frac_q || p_exp_q;
        else if (c == `SCP_CH_PLUS || c == `SCP_CH_DASH)
          fail_c = has_p_q && !p_exp_q;
        else if (is_alpha(c))
          fail_c = has_p_q && (p_str_q ? kw_q[63:56] != 8'h00 : (c != `SCP_CH_EXP || p_exp_q));
        else if (c == `SCP_CH_SP || c == `SCP_CH_COMMA || term)
        begin
          fail_c = !has_p_q || (p_str_q && !str_ok);
          end_c = term;
        end
        else
          fail_c = 1'b1;
      SCP_P_PEND:
      begin
        fail_c = !(c == `SCP_CH_SP || c == `SCP_CH_COMMA || term);
        end_c = term;
      end
      SCP_P_COMMA: fail_c = !(c == `SCP_CH_SP || c == `SCP_CH_LPAR);
      SCP_P_AT: fail_c = c != `SCP_CH_AT;
      SCP_P_CHN:
        if (is_digit(c))
          fail_c = int'(chn_nx) >= CHANNELS;
        else if (c == `SCP_CH_DASH)
          fail_c = !chd_q || rng_q;
        else if (c == `SCP_CH_COMMA || c == `SCP_CH_RPAR)
          fail_c = !chd_q || (rng_q && lo_q > chn_q);
        else
          fail_c = 1'b1;
      SCP_P_TAIL:
      begin
        fail_c = !(c == `SCP_CH_SP || term);
        end_c = term;
      end
      default: fail_c = 1'b1;
    endcase
  end

  // line capture, two-pass parse, execution and answer sequencing
  always_ff @(posedge mclk or negedge rst_sync_b_q)
  begin
    if (!rst_sync_b_q)
    begin
      st_q <= SCP_S_RX;
      nxt_q <= SCP_S_ANS;
      ph_q <= SCP_P_LEAD;
      level_q <= SCP_LV_ROOT;
      cmd_q <= SCP_CMD_NONE;
      {pass2_q, prev_cr_q, bad_q, query_q, has_p_q, p_str_q} <= 6'h00;
      {p_neg_q, p_frac_q, p_exp_q, chd_q, rng_q, any_ans_q, first_ch_q} <= 7'h00;
      p_q <= '0;
      len_q <= '0;
      kw_q <= 64'h0;
      val_q <= 32'h0;
      chn_q <= 8'h00;
      lo_q <= 8'h00;
      sep_q <= `SCP_CH_SEMI;
      mask_q <= '0;
      work_q <= '0;
    end
    else
    begin
      case (st_q)
        SCP_S_RX:
          if (rx_take)
          begin
            prev_cr_q <= rx_data == `SCP_CH_CR;
            if (line_end)
            begin
              bad_q <= 1'b0;
              p_q <= '0;
              ph_q <= SCP_P_LEAD;
              level_q <= SCP_LV_ROOT;
              pass2_q <= 1'b0;
              any_ans_q <= 1'b0;
              if (bad_q)
                len_q <= '0;
              else
                st_q <= SCP_S_FETCH;
            end
            else if (rx_store)
            begin
              if (int'(len_q) < DEPTH)
                len_q <= len_q + AW'(1);
              else
                bad_q <= 1'b1;
              if (rx_data[7])
                bad_q <= 1'b1;
            end
          end
        SCP_S_FETCH: st_q <= SCP_S_CHAR;
        SCP_S_CHAR:
        begin
          st_q <= SCP_S_FETCH;
          p_q <= p_q + AW'(1);
          if (fail_c)
          begin
            st_q <= SCP_S_RX;
            len_q <= '0;
          end
          else if (ph_q == SCP_P_LEAD && c == `SCP_CH_EOL)
          begin
            p_q <= '0;
            level_q <= SCP_LV_ROOT;
            pass2_q <= 1'b1;
            if (pass2_q)
            begin
              st_q <= any_ans_q ? SCP_S_CR : SCP_S_RX;
              len_q <= '0;
            end
          end
          else if (end_c)
          begin
            ph_q <= SCP_P_LEAD;
            if (pass2_q)
            begin
              st_q <= SCP_S_EXEC;
              work_q <= (mask_q == '0) ? CHANNELS'(1) : mask_q;
              first_ch_q <= 1'b1;
            end
          end
          else
            case (eph)
              SCP_P_LEAD:
                if (c != `SCP_CH_SP)
                begin
                  ph_q <= SCP_P_KW;
                  {query_q, has_p_q, p_str_q, p_neg_q, p_frac_q, p_exp_q} <= 6'h00;
                  val_q <= 32'h0;
                  mask_q <= '0;
                  kw_q <= (c == `SCP_CH_COLON) ? 64'h0 : {56'h0, c};
                  if (c == `SCP_CH_COLON)
                    level_q <= SCP_LV_ROOT;
                end
              SCP_P_KW:
                if (c == `SCP_CH_COLON)
                begin
                  level_q <= SCP_LV_MEAS;
                  kw_q <= 64'h0;
                end
                else if (c == `SCP_CH_QUERY || c == `SCP_CH_SP)
                begin
                  cmd_q <= leaf;
                  query_q <= c == `SCP_CH_QUERY;
                  ph_q <= SCP_P_POST;
                end
                else
                  kw_q <= kw_nx;
              SCP_P_POST:
                if (c == `SCP_CH_LPAR)
                  ph_q <= SCP_P_AT;
              SCP_P_PARAM:
              begin
                has_p_q <= 1'b1;
                ph_q <= SCP_P_PARAM;
                if (c == `SCP_CH_SP)
                  ph_q <= SCP_P_PEND;
                else if (c == `SCP_CH_COMMA)
                  ph_q <= SCP_P_COMMA;
                else if (is_digit(c) && !p_frac_q && !p_exp_q)
                  val_q <= val_nx[31:0];
                else if (c == `SCP_CH_DOT)
                  p_frac_q <= 1'b1;
                else if (c == `SCP_CH_DASH && !p_exp_q)
                  p_neg_q <= 1'b1;
                else if (is_alpha(c) && has_p_q && !p_str_q)
                  p_exp_q <= 1'b1;
                else if (is_alpha(c))
                begin
                  p_str_q <= 1'b1;
                  kw_q <= str_nx;
                  val_q <= {31'h0, str_nx == 64'("ON")};
                end
              end
              SCP_P_PEND:
                if (c == `SCP_CH_COMMA)
                  ph_q <= SCP_P_COMMA;
              SCP_P_COMMA:
                if (c == `SCP_CH_LPAR)
                  ph_q <= SCP_P_AT;
              SCP_P_AT:
              begin
                ph_q <= SCP_P_CHN;
                {chd_q, rng_q} <= 2'b00;
                chn_q <= 8'h00;
              end
              SCP_P_CHN:
                if (is_digit(c))
                begin
                  chn_q <= chn_nx[7:0];
                  chd_q <= 1'b1;
                end
                else
                begin
                  chn_q <= 8'h00;
                  chd_q <= 1'b0;
                  rng_q <= c == `SCP_CH_DASH;
                  lo_q <= chn_q;
                  if (c != `SCP_CH_DASH)
                    mask_q <= mask_q | span(rng_q ? lo_q : chn_q, chn_q);
                  if (c == `SCP_CH_RPAR)
                    ph_q <= SCP_P_TAIL;
                end
              default: ph_q <= ph_q;
            endcase
        end
        SCP_S_EXEC:
        begin
          first_ch_q <= 1'b0;
          work_q <= work_nx;
          sep_q <= first_ch_q ? `SCP_CH_SEMI : `SCP_CH_COMMA;
          nxt_q <= (cmd_q == SCP_CMD_OPC) ? SCP_S_OPC : SCP_S_ANS;
          if (query_q)
          begin
            any_ans_q <= 1'b1;
            if (any_ans_q)
              st_q <= SCP_S_SEP;
            else
              st_q <= (cmd_q == SCP_CMD_OPC) ? SCP_S_OPC : SCP_S_ANS;
          end
          else if (work_nx == '0)
            st_q <= SCP_S_FETCH;
        end
        SCP_S_SEP:
          if (tx_take && loaded_q)
            st_q <= nxt_q;
        SCP_S_ANS:
          if (ans_take && ans_last)
            st_q <= (work_q == '0) ? SCP_S_FETCH : SCP_S_EXEC;
        SCP_S_OPC:
          if (tx_take && loaded_q)
            st_q <= SCP_S_FETCH;
        SCP_S_CR:
          if (tx_take && loaded_q)
            st_q <= SCP_S_LF;
        SCP_S_LF:
          if (tx_take && loaded_q)
            st_q <= SCP_S_RX;
        default: st_q <= SCP_S_RX;
      endcase
    end
  end

  // receive handshake and echo
  always_ff @(posedge mclk or negedge rst_sync_b_q)
  begin
    if (!rst_sync_b_q)
    begin
      rx_ready <= 1'b0;
      echo_valid <= 1'b0;
      echo_data <= 8'h00;
      line_error <= 1'b0;
    end
    else
    begin
      rx_ready <= st_q == SCP_S_RX && !line_end;
      echo_valid <= rx_take;
      echo_data <= rx_data;
      line_error <= (st_q == SCP_S_CHAR && fail_c) || (line_end && bad_q);
    end
  end

  // command strobes towards the executor
  always_ff @(posedge mclk or negedge rst_sync_b_q)
  begin
    if (!rst_sync_b_q)
    begin
      cmd_valid <= 1'b0;
      cmd_code <= SCP_CMD_NONE;
      cmd_query <= 1'b0;
      cmd_chan <= '0;
      cmd_value <= 32'h0;
      cmd_neg <= 1'b0;
      cmd_first_q <= 1'b0;
      ch_last_q <= '0;
    end
    else
    begin
      cmd_valid <= st_q == SCP_S_EXEC && cmd_q != SCP_CMD_OPC;
      cmd_code <= cmd_q;
      cmd_query <= query_q;
      cmd_chan <= ch;
      cmd_value <= val_q;
      cmd_neg <= p_neg_q;
      cmd_first_q <= first_ch_q;
      if (cmd_valid)
        ch_last_q <= cmd_chan;
    end
  end

  // answer stream with separators and line end
  always_ff @(posedge mclk or negedge rst_sync_b_q)
  begin
    if (!rst_sync_b_q)
    begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      ans_ready <= 1'b0;
      loaded_q <= 1'b0;
    end
    else
    begin
      ans_ready <= st_q == SCP_S_ANS && !tx_valid && !ans_take;
      if (tx_take)
      begin
        tx_valid <= 1'b0;
        loaded_q <= 1'b0;
      end
      if (ans_take)
      begin
        tx_valid <= 1'b1;
        tx_data <= {1'b0, ans_data[6:0]};
      end
      else if (!tx_valid && !loaded_q && (st_q == SCP_S_SEP || st_q == SCP_S_OPC
        || st_q == SCP_S_CR || st_q == SCP_S_LF))
      begin
        tx_valid <= 1'b1;
        loaded_q <= 1'b1;
        case (st_q)
          SCP_S_SEP: tx_data <= sep_q;
          SCP_S_OPC: tx_data <= `SCP_CH_ONE;
          SCP_S_CR: tx_data <= `SCP_CH_CR;
          default: tx_data <= `SCP_CH_LF;
        endcase
      end
    end
  end

  echo_copy_a: assert property (@(posedge mclk) disable iff (!rst_sync_b_q)
    rx_valid && rx_ready |=> echo_valid && echo_data == $past(rx_data))
    else $error("received character not echoed");

  seven_bit_a: assert property (@(posedge mclk) disable iff (!rst_sync_b_q)
    tx_valid |-> !tx_data[7])
    else $error("answer byte outside seven-bit range");

  crlf_pair_a: assert property (@(posedge mclk) disable iff (!rst_sync_b_q)
    tx_take && tx_data == `SCP_CH_CR |-> ##[1:2] tx_valid && tx_data == `SCP_CH_LF)
    else $error("carriage return not followed by line feed");

  error_silent_a: assert property (@(posedge mclk) disable iff (!rst_sync_b_q)
    line_error |-> st_q == SCP_S_RX && !tx_valid && !cmd_valid)
    else $error("answer or command after a line error");

  order_silent_a: assert property (@(posedge mclk) disable iff (!rst_sync_b_q)
    cmd_valid && !cmd_query |=> !ans_ready)
    else $error("order command waited for an answer");

  checked_first_a: assert property (@(posedge mclk) disable iff (!rst_sync_b_q)
    cmd_valid |-> pass2_q)
    else $error("command issued before its line was checked");

  chan_range_a: assert property (@(posedge mclk) disable iff (!rst_sync_b_q)
    cmd_valid |-> ((mask_q == '0) ? cmd_chan == '0 : mask_q[cmd_chan]))
    else $error("channel number out of range");

  chan_order_a: assert property (@(posedge mclk) disable iff (!rst_sync_b_q)
    cmd_valid && !cmd_first_q |-> cmd_chan > ch_last_q)
    else $error("channels not served in ascending order");

  opc_one_a: assert property (@(posedge mclk) disable iff (!rst_sync_b_q)
    st_q == SCP_S_OPC && tx_valid && loaded_q |-> tx_data == `SCP_CH_ONE)
    else $error("operation-complete answer is not one");
endmodule

// File: sim/scp_exec_model.sv
`timescale 1ns/1ps
// executor stand-in: answers every query with one ascii digit, the channel number
module scp_exec_model
  import scp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic cmd_query,
  input wire logic [2:0] cmd_chan,
  input wire logic ans_ready,
  output logic ans_valid,
  output logic [7:0] ans_data,
  output logic ans_last
);
  logic [7:0] byte_q;
  int wait_q;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ans_valid <= 1'b0;
      ans_last <= 1'b0;
      ans_data <= 8'h55;
      byte_q <= 8'h00;
      wait_q <= 0;
    end
    else if (cmd_valid && cmd_query)
    begin
      byte_q <= 8'h30 + {5'h00, cmd_chan};
      wait_q <= $urandom_range(3, 1);
    end
    else if (wait_q > 1)
      wait_q <= wait_q - 1;
    else if (wait_q == 1)
    begin
      ans_valid <= 1'b1;
      ans_last <= 1'b1;
      ans_data <= byte_q;
      wait_q <= 0;
    end
    else if (ans_valid && ans_ready)
    begin
      ans_valid <= 1'b0;
      ans_last <= 1'b0;
      // released bus shows no stale byte
      ans_data <= ~ans_data;
    end
  end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import scp_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic tx_ready = 1'b0;
  logic rx_ready, echo_valid, cmd_valid, cmd_query, cmd_neg, ans_valid, ans_last;
  logic ans_ready, tx_valid, line_error, took;
  logic [7:0] echo_data, ans_data, tx_data;
  logic [2:0] cmd_chan;
  logic [31:0] cmd_value;
  scp_cmd_t cmd_code;
  int n_errors = 0;
  int checked = 0;
  int errs = 0;
  logic [7:0] echoq[$];
  logic [7:0] txq[$];
  logic [63:0] cmdq[$];

  always #50 mclk = ~mclk;

  scp_parser u_dut (.mclk(mclk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .echo_valid(echo_valid), .echo_data(echo_data),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_query(cmd_query),
    .cmd_chan(cmd_chan), .cmd_value(cmd_value), .cmd_neg(cmd_neg),
    .ans_valid(ans_valid), .ans_data(ans_data), .ans_last(ans_last),
    .ans_ready(ans_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .line_error(line_error));

  scp_exec_model u_exec (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_query(cmd_query), .cmd_chan(cmd_chan), .ans_ready(ans_ready),
    .ans_valid(ans_valid), .ans_data(ans_data), .ans_last(ans_last));

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic void exp(scp_cmd_t c, logic q, int ch, int unsigned v);
    cmdq.push_back({24'h000000, 1'b0, c, q, 3'(ch), 32'(v)});
  endfunction

  always @(posedge mclk)
  begin
    took <= rx_valid && rx_ready;
    if (echo_valid === 1'b1)
      cmp_byte(echo_data, echoq.size() ? echoq.pop_front() : 8'hxx);
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      cmp_byte(tx_data, txq.size() ? txq.pop_front() : 8'hxx);
    if (cmd_valid === 1'b1)
      cmp_word({24'h0, cmd_neg, cmd_code, cmd_query, cmd_chan, cmd_value},
        cmdq.size() ? cmdq.pop_front() : 64'hx);
    if (line_error === 1'b1)
      errs++;
  end

  // far side stalls the answer stream at random
  always @(posedge mclk)
  begin
    #1;
    tx_ready = 1'($urandom_range(1, 0));
  end

  task automatic line(input string s, input string tx, input int err);
    int k;
    errs = 0;
    for (int i = 0; i < tx.len(); i++)
      txq.push_back(tx[i]);
    if (tx.len() > 0)
    begin
      txq.push_back(8'h0d);
      txq.push_back(8'h0a);
    end
    s = {s, "\r\n"};
    for (int i = 0; i < s.len(); i++)
    begin
      rx_valid = 1'b1;
      rx_data = s[i];
      echoq.push_back(s[i]);
      k = 0;
      do
      begin
        @(posedge mclk);
        #1;
        k++;
      end
      while (!took && k < 300);
      cmp_word(64'(took), 64'h1);
    end
    rx_valid = 1'b0;
    k = 0;
    while (rx_ready !== 1'b1 || txq.size() != 0 || k < 3)
    begin
      @(posedge mclk);
      #1;
      k++;
      if (k > 3000)
      begin
        n_errors++;
        $display("[FAIL] %0t line wait got %h exp %h", $time, k, 3000);
        break;
      end
    end
    cmp_word(64'(errs), 64'(err));
    cmp_word(64'(cmdq.size() + txq.size()), 64'h0);
  endtask

  initial
  begin
    #(100 * 60000);
    n_errors++;
    conclude();
  end

  initial
  begin
    int v;
    int c;
    void'($urandom(8413));
    repeat (10) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    exp(SCP_CMD_VOLT, 1'b0, 0, 5);
    exp(SCP_CMD_VOLT, 1'b0, 1, 5);
    exp(SCP_CMD_VOLT, 1'b0, 3, 5);
    line(":VOLT 5,(@0-1,3)", "", 0);
    exp(SCP_CMD_VOLT, 1'b0, 0, 7);
    line("  volt   7  ", "", 0);
    cmdq.push_back({24'h0, 1'b1, SCP_CMD_VOLT, 1'b0, 3'h0, 32'hc});
    line("VOLT -12.5E-3", "", 0);
    exp(SCP_CMD_MEAS_VOLT, 1'b1, 0, 0);
    exp(SCP_CMD_MEAS_VOLT, 1'b1, 2, 0);
    exp(SCP_CMD_MEAS_CURR, 1'b1, 5, 0);
    line("MEAS:VOLT? (@0,2);CURR? (@5)", "0,2;5", 0);
    exp(SCP_CMD_MEAS_CURR, 1'b1, 4, 0);
    line(":MEASURE:current? (@4)", "4", 0);
    exp(SCP_CMD_CURR, 1'b0, 0, 1);
    line("CURRENT ON;*OPC?", "1", 0);
    line("VOLT 5;FOO 1", "", 1);
    line("VOLT 1,(@8)", "", 1);
    line("VOLT 4294967296", "", 1);
    line("MEAS:VOLT? (@3-1)", "", 1);
    for (int i = 0; i < 6; i++)
    begin
      v = $urandom_range(99999, 0);
      c = $urandom_range(7, 0);
      exp(SCP_CMD_CURR, 1'b0, c, v);
      exp(SCP_CMD_MEAS_VOLT, 1'b1, c, 0);
      line($sformatf("CURR %0d,(@%0d);:MEAS:VOLT? (@%0d)", v, c, c),
        $sformatf("%0d", c), 0);
    end
    conclude();
  end
endmodule
